// ### pae_alarm_unit.v
// four-alarm evaluator with an AHB-Lite register slave
// assumes process inputs come from hclk logic, keys and events from pins
//
// What this block does
// - separate upper and lower limits per alarm
// - rate alarm compares period-to-period value difference
// - rate period counted in 50 ms sampling cycles
// - threshold sign selects rising or falling direction
// - rate period 1 to 999, default 20
// - set-point alarms use ramp or target set point
// - manipulated-value upper and lower alarms with hysteresis
// - remote set-point upper and lower alarms with hysteresis
// - separate hysteresis per alarm on switching
// - hysteresis defaults 0.2/0.02% FS, MV 0.50%
// - standby suppresses until range left then reentered
// - standby cancelled on output, rearmed per setting
// - latch holds alarm on until cleared
// - latch cleared at reset and setting levels
// - function key or event input clears latch
// - alarm type resets to deviation upper, code 2
// - type 8 compares process value to alarm value
// - heating/cooling: upper uses heat, lower cool
// - type 5 stays off on hysteresis overlap
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pae_consts.vh"
module pae_alarm_unit #(
  parameter DW = 16,
  parameter NA = 4,
  parameter SAMPLE_CYC = `PAE_SAMPLE_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire signed [DW-1:0] process_value,
  input wire signed [DW-1:0] set_point,
  input wire signed [DW-1:0] target_set_point,
  input wire signed [DW-1:0] manipulated_value,
  input wire signed [DW-1:0] manipulated_value_cool,
  input wire signed [DW-1:0] remote_set_point,
  input wire function_key,
  input wire event_latch_release,
  output wire [NA-1:0] alarm_out
);
  localparam EW = DW + 2;
  localparam PW = 10;
  localparam TW = 21;
  localparam [31:0] TICK_LAST_W = SAMPLE_CYC - 1;
  localparam [TW-1:0] TICK_LAST = TICK_LAST_W[TW-1:0];

  // sampling tick
  reg [TW-1:0] tick_cnt_r;
  reg tick_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= {TW{1'b0}};
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_LAST);
      if (tick_cnt_r == TICK_LAST) begin
        tick_cnt_r <= {TW{1'b0}};
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // pin synchronisers and rising edges
  reg [1:0] fk_sync_r;
  reg [1:0] ev_sync_r;
  reg fk_d_r;
  reg ev_d_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fk_sync_r <= 2'h0;
      ev_sync_r <= 2'h0;
      fk_d_r <= 1'b0;
      ev_d_r <= 1'b0;
    end else begin
      fk_sync_r <= {fk_sync_r[0], function_key};
      ev_sync_r <= {ev_sync_r[0], event_latch_release};
      fk_d_r <= fk_sync_r[1];
      ev_d_r <= ev_sync_r[1];
    end
  end
  wire key_clr = (fk_sync_r[1] & ~fk_d_r) | (ev_sync_r[1] & ~ev_d_r);

  // bus address and data phases
  reg wr_pend_r;
  reg rd_pend_r;
  reg [7:0] addr_r;
  wire take = hsel & hready & htrans[1];
  assign hreadyout = ~rd_pend_r;
  assign hresp = 1'b0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      if (take) begin
        addr_r <= {haddr[7:2], 2'h0};
      end
      wr_pend_r <= take & hwrite;
      rd_pend_r <= take & ~hwrite;
    end
  end
  wire [3:0] blk = addr_r[7:4];
  wire [1:0] fld = addr_r[3:2];
  wire alm_hit = (blk >= 4'h1) && (blk <= NA);
  wire [1:0] ai = blk[1:0] - 2'h1;

  // registers
  reg [15:0] ctrl_r;
  reg [PW-1:0] rate_r;
  reg [4:0] type_r [0:NA-1];
  reg [DW-1:0] val_r [0:NA-1];
  reg [DW-1:0] hi_r [0:NA-1];
  reg [DW-1:0] lo_r [0:NA-1];
  reg [DW-1:0] hys_r [0:NA-1];
  reg lvl_clr_r;
  wire [2:0] lvl_new = hwdata[`PAE_CTRL_LEVEL+2:`PAE_CTRL_LEVEL];
  wire [2:0] lvl_old = ctrl_r[`PAE_CTRL_LEVEL+2:`PAE_CTRL_LEVEL];
  wire [PW-1:0] rate_in = hwdata[PW-1:0];
  wire mv_new = (hwdata[4:0] == 5'h10) | (hwdata[4:0] == 5'h11);
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 16'h0000;
      rate_r <= `PAE_RATE_RST;
      lvl_clr_r <= 1'b0;
      for (i = 0; i < NA; i = i + 1) begin
        type_r[i] <= `PAE_TYPE_RST;
        val_r[i] <= `PAE_VAL_RST;
        hi_r[i] <= `PAE_VAL_RST;
        lo_r[i] <= `PAE_VAL_RST;
        hys_r[i] <= `PAE_HYS_RST;
      end
    end else begin
      lvl_clr_r <= 1'b0;
      if (wr_pend_r && addr_r == `PAE_OFS_CTRL) begin
        ctrl_r <= {5'h00, hwdata[10:8], hwdata[7:4], 1'b0, hwdata[2:0]};
        // entering a setting level drops latches
        lvl_clr_r <= (lvl_new >= `PAE_LVL_INIT) && (lvl_new <= `PAE_LVL_CAL)
                     && (lvl_new != lvl_old);
      end
      if (wr_pend_r && addr_r == `PAE_OFS_RATE) begin
        if (rate_in < `PAE_RATE_MIN) begin
          rate_r <= `PAE_RATE_MIN;
        end else if (rate_in > `PAE_RATE_MAX) begin
          rate_r <= `PAE_RATE_MAX;
        end else begin
          rate_r <= rate_in;
        end
      end
      if (wr_pend_r && alm_hit) begin
        case (fld)
          `PAE_FLD_TYPE: begin
            type_r[ai] <= hwdata[4:0];
            // class change reloads the class default
            if (mv_new != ((type_r[ai] == 5'h10) | (type_r[ai] == 5'h11))) begin
              hys_r[ai] <= mv_new ? `PAE_HYS_MV_RST : `PAE_HYS_RST;
            end
          end
          `PAE_FLD_VAL: val_r[ai] <= hwdata[DW-1:0];
          `PAE_FLD_LIM: begin
            lo_r[ai] <= hwdata[DW-1:0];
            hi_r[ai] <= hwdata[DW+15:16];
          end
          `PAE_FLD_HYS: hys_r[ai] <= hwdata[DW-1:0];
          default: hys_r[ai] <= hys_r[ai];
        endcase
      end
    end
  end

  // read data, loaded during the read wait cycle
  wire [NA-1:0] armed;
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (addr_r == `PAE_OFS_CTRL) begin
      rd_mux = {16'h0000, ctrl_r};
    end else if (addr_r == `PAE_OFS_RATE) begin
      rd_mux = {22'h000000, rate_r};
    end else if (addr_r == `PAE_OFS_STAT) begin
      rd_mux = {24'h000000, armed, alarm_out};
    end else if (alm_hit) begin
      case (fld)
        `PAE_FLD_TYPE: rd_mux = {27'h0000000, type_r[ai]};
        `PAE_FLD_VAL: rd_mux = {16'h0000, val_r[ai]};
        `PAE_FLD_LIM: rd_mux = {hi_r[ai], lo_r[ai]};
        default: rd_mux = {16'h0000, hys_r[ai]};
      endcase
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_r) begin
      hrdata <= rd_mux;
    end
  end

  // rate of change
  wire signed [DW:0] rate_diff;
  wire rate_valid;
  pae_rate_calc #(.DW(DW), .PW(PW)) u_rate (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick_r),
    .period(rate_r),
    .value(process_value),
    .diff_r(rate_diff),
    .valid_r(rate_valid)
  );

  // shared operands, widened
  wire signed [EW-1:0] pv_e = {{2{process_value[DW-1]}}, process_value};
  wire signed [EW-1:0] sp_e = {{2{set_point[DW-1]}}, set_point};
  wire signed [EW-1:0] tsp_e = {{2{target_set_point[DW-1]}}, target_set_point};
  wire signed [EW-1:0] mvh_e = {{2{manipulated_value[DW-1]}}, manipulated_value};
  wire signed [EW-1:0] mvc_e =
    {{2{manipulated_value_cool[DW-1]}}, manipulated_value_cool};
  wire signed [EW-1:0] rsp_e = {{2{remote_set_point[DW-1]}}, remote_set_point};
  wire signed [EW-1:0] dif_e = {rate_diff[DW], rate_diff};
  wire signed [EW-1:0] spa_e = ctrl_r[`PAE_CTRL_SPSEL] ? tsp_e : sp_e;
  wire heat_cool = ctrl_r[`PAE_CTRL_HEATCOOL];
  wire clr = lvl_clr_r | key_clr;

  genvar g;
  generate
    for (g = 0; g < NA; g = g + 1) begin : alm
      wire [4:0] ty = type_r[g];
      wire signed [EW-1:0] x_e = {{2{val_r[g][DW-1]}}, val_r[g]};
      wire signed [EW-1:0] h_e = {{2{hi_r[g][DW-1]}}, hi_r[g]};
      wire signed [EW-1:0] l_e = {{2{lo_r[g][DW-1]}}, lo_r[g]};
      wire signed [EW-1:0] hy_e = {{2{hys_r[g][DW-1]}}, hys_r[g]};
      wire signed [EW-1:0] dhi = sp_e + h_e;
      wire signed [EW-1:0] dlo = sp_e - l_e;
      wire ovl = (dhi - hy_e) <= (dlo + hy_e);
      reg [2:0] kind;
      reg sb;
      reg use_rate;
      reg signed [EW-1:0] v;
      reg signed [EW-1:0] thh;
      reg signed [EW-1:0] thl;
      always @* begin
        kind = `PAE_K_OFF;
        sb = 1'b0;
        use_rate = 1'b0;
        v = pv_e;
        thh = sp_e + x_e;
        thl = sp_e - x_e;
        case (ty)
          5'h01, 5'h05: begin
            kind = (ty == 5'h05 && ovl) ? `PAE_K_OFF : `PAE_K_DUAL;
            sb = (ty == 5'h05);
            thh = dhi;
            thl = dlo;
          end
          5'h02, 5'h06: begin
            kind = `PAE_K_UP;
            sb = (ty == 5'h06);
          end
          5'h03, 5'h07: begin
            kind = `PAE_K_LO;
            sb = (ty == 5'h07);
          end
          5'h04: begin
            kind = `PAE_K_RANGE;
            thh = dhi;
            thl = dlo;
          end
          5'h08, 5'h0a: begin
            kind = `PAE_K_UP;
            sb = (ty == 5'h0a);
            thh = x_e;
          end
          5'h09, 5'h0b: begin
            kind = `PAE_K_LO;
            sb = (ty == 5'h0b);
            thl = x_e;
          end
          5'h0d: begin
            use_rate = 1'b1;
            v = dif_e;
            kind = x_e[EW-1] ? `PAE_K_LO : `PAE_K_UP;
            thh = x_e;
            thl = x_e;
          end
          5'h0e, 5'h0f: begin
            kind = (ty == 5'h0e) ? `PAE_K_UP : `PAE_K_LO;
            v = spa_e;
            thh = x_e;
            thl = x_e;
          end
          5'h10: begin
            kind = `PAE_K_UP;
            v = mvh_e;
            thh = x_e;
          end
          5'h11: begin
            kind = `PAE_K_LO;
            v = heat_cool ? mvc_e : mvh_e;
            thl = x_e;
          end
          5'h12, 5'h13: begin
            kind = (ty == 5'h12) ? `PAE_K_UP : `PAE_K_LO;
            v = rsp_e;
            thh = x_e;
            thl = x_e;
          end
          default: kind = `PAE_K_OFF;
        endcase
      end
      pae_alarm_eval #(.W(EW)) u_eval (
        .hclk(hclk),
        .hresetn(hresetn),
        .eval(use_rate ? rate_valid : tick_r),
        .kind(kind),
        .standby(sb),
        .value(v),
        .th_hi(thh),
        .th_lo(thl),
        .hys(hy_e),
        .latch_en(ctrl_r[`PAE_CTRL_LATCH+g]),
        .clear(clr),
        .rearm(clr),
        .rearm_on_off(ctrl_r[`PAE_CTRL_REARM]),
        .out_r(alarm_out[g]),
        .armed_r(armed[g])
      );
    end
  endgenerate
endmodule

// ### pae_consts.vh
// constants of the process alarm evaluator
// assumes a 25 MHz hclk and a 32-bit AHB-Lite register bus
`ifndef PAE_CONSTS_VH
`define PAE_CONSTS_VH
`define PAE_CLK_PERIOD_NS 40
`define PAE_SAMPLE_MS 50
`define PAE_SAMPLE_CYC (`PAE_SAMPLE_MS * 1000000 / `PAE_CLK_PERIOD_NS)
`define PAE_OFS_CTRL 8'h00
`define PAE_OFS_RATE 8'h04
`define PAE_OFS_STAT 8'h08
`define PAE_FLD_TYPE 2'h0
`define PAE_FLD_VAL 2'h1
`define PAE_FLD_LIM 2'h2
`define PAE_FLD_HYS 2'h3
`define PAE_CTRL_SPSEL 0
`define PAE_CTRL_HEATCOOL 1
`define PAE_CTRL_REARM 2
`define PAE_CTRL_LATCH 4
`define PAE_CTRL_LEVEL 8
`define PAE_LVL_INIT 3'h2
`define PAE_LVL_CAL 3'h5
`define PAE_RATE_MIN 10'h001
`define PAE_RATE_MAX 10'h3e7
`define PAE_RATE_RST 10'h014
`define PAE_TYPE_RST 5'h02
`define PAE_VAL_RST 16'h000a
`define PAE_HYS_RST 16'h0002
`define PAE_HYS_MV_RST 16'h0032
`define PAE_K_OFF 3'h0
`define PAE_K_UP 3'h1
`define PAE_K_LO 3'h2
`define PAE_K_DUAL 3'h3
`define PAE_K_RANGE 3'h4
`endif

// ### pae_rate_calc.v
// rate-of-change difference of the process value
// assumes tick is a one-cycle pulse per sampling cycle on hclk
`timescale 1ns/1ps
module pae_rate_calc #(
  parameter DW = 16,
  parameter PW = 10
) (
  input wire hclk,
  input wire hresetn,
  input wire tick,
  input wire [PW-1:0] period,
  input wire signed [DW-1:0] value,
  output reg signed [DW:0] diff_r,
  output reg valid_r
);
  reg [PW-1:0] cnt_r;
  reg signed [DW-1:0] prev_r;
  reg have_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {PW{1'b0}};
      prev_r <= {DW{1'b0}};
      have_r <= 1'b0;
      diff_r <= {(DW+1){1'b0}};
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      if (tick) begin
        if (cnt_r + 1'b1 >= period) begin
          cnt_r <= {PW{1'b0}};
          prev_r <= value;
          have_r <= 1'b1;
          diff_r <= {value[DW-1], value} - {prev_r[DW-1], prev_r};
          valid_r <= have_r;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule

// ### pae_alarm_eval.v
// one alarm: hysteresis, standby sequence and latch
// assumes thresholds and kind are settled when eval pulses
`timescale 1ns/1ps
`include "pae_consts.vh"
module pae_alarm_eval #(
  parameter W = 18
) (
  input wire hclk,
  input wire hresetn,
  input wire eval,
  input wire [2:0] kind,
  input wire standby,
  input wire signed [W-1:0] value,
  input wire signed [W-1:0] th_hi,
  input wire signed [W-1:0] th_lo,
  input wire signed [W-1:0] hys,
  input wire latch_en,
  input wire clear,
  input wire rearm,
  input wire rearm_on_off,
  output reg out_r,
  output reg armed_r
);
  reg hi_r;
  reg lo_r;
  reg left_r;
  reg raw;
  wire signed [W-1:0] hi_off = th_hi - hys;
  wire signed [W-1:0] lo_off = th_lo + hys;
  // on past the point, off only once back by hys
  wire hi_nxt = (value > th_hi) | (hi_r & (value > hi_off));
  wire lo_nxt = (value < th_lo) | (lo_r & (value < lo_off));
  always @* begin
    case (kind)
      `PAE_K_UP: raw = hi_nxt;
      `PAE_K_LO: raw = lo_nxt;
      `PAE_K_DUAL: raw = hi_nxt | lo_nxt;
      `PAE_K_RANGE: raw = ~hi_nxt & ~lo_nxt;
      default: raw = 1'b0;
    endcase
  end
  // suppressed while armed until range left once
  wire gated = raw & (~standby | ~armed_r | left_r);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
      out_r <= 1'b0;
      armed_r <= 1'b1;
      left_r <= 1'b0;
    end else begin
      if (eval) begin
        hi_r <= hi_nxt;
        lo_r <= lo_nxt;
        out_r <= gated | (latch_en & out_r & ~clear);
      end else if (clear) begin
        out_r <= 1'b0;
      end
      if (rearm | (rearm_on_off & eval & ~gated & ~armed_r)) begin
        armed_r <= 1'b1;
        left_r <= 1'b0;
      end else if (eval & standby & armed_r) begin
        if (gated) begin
          armed_r <= 1'b0;
        end else if (~raw) begin
          left_r <= 1'b1;
        end
      end
    end
  end
endmodule

// ### pae_alarm_unit_sva.sv
// port checker of the four-alarm evaluator
// assumes sampling tick period SAMPLE_CYC, counted from reset release
`timescale 1ns/1ps
module pae_alarm_unit_chk #(
  parameter NA = 4,
  parameter SAMPLE_CYC = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [NA-1:0] alarm_out
);
  integer cnt_r;
  reg tk_r;
  wire take = hsel && hready && htrans[1];
  // mirror of the sampling tick
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 0;
      tk_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == SAMPLE_CYC - 1) ? 0 : cnt_r + 1;
      tk_r <= (cnt_r == SAMPLE_CYC - 1);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  rise_on_tick_a: assert property ((alarm_out & ~$past(alarm_out)) != 0 |->
    $past(tk_r) || $past(tk_r, 2)) else $error("alarm rose off the tick");
  reset_clear_a: assert property ($rose(hresetn) |-> alarm_out == 0 && hreadyout)
    else $error("outputs not at reset values");
  early_quiet_a: assert property ($rose(hresetn) |-> (alarm_out == 0) [*8])
    else $error("alarm before first tick");
  okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  wait_cause_a: assert property (!hreadyout |-> $past(take && !hwrite))
    else $error("wait outside read");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data moved");
  cover property (take && !hwrite);
  cover property ($rose(alarm_out[0]));
  cover property ($fell(alarm_out[2]));
endmodule
bind pae_alarm_unit pae_alarm_unit_chk #(.NA(NA), .SAMPLE_CYC(SAMPLE_CYC)) i_pae_alarm_unit_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .alarm_out(alarm_out));

// ### pae_plant.sv
// plant and operator side: process inputs and latch clear pins
// assumes the bench calls set_pv and press from its main sequence
`timescale 1ns/1ps
module pae_plant (
  input wire hclk,
  output logic signed [15:0] pv,
  output logic signed [15:0] sp,
  output logic signed [15:0] tsp,
  output logic signed [15:0] mv,
  output logic signed [15:0] mvc,
  output logic signed [15:0] rsp,
  output logic key,
  output logic evt
);
  initial begin
    pv = 100; sp = 100; tsp = 200; mv = 60; mvc = 80; rsp = 60;
    key = 1'b0;
    evt = 1'b0;
  end
  task set_pv(input logic signed [15:0] v);
    @(posedge hclk);
    pv <= v;
  endtask
  // 0 pv, 1 ramp sp, 2 target sp, 3 mv, 4 cool mv, other rsp
  task set_in(input int sel, input logic signed [15:0] v);
    @(posedge hclk);
    case (sel)
      0: pv <= v;
      1: sp <= v;
      2: tsp <= v;
      3: mv <= v;
      4: mvc <= v;
      default: rsp <= v;
    endcase
  endtask
  // clear request held a few cycles
  task press(input bit ev);
    @(posedge hclk);
    if (ev) evt <= 1'b1; else key <= 1'b1;
    repeat (4) @(posedge hclk);
    key <= 1'b0;
    evt <= 1'b0;
  endtask
endmodule

// ### pae_alarm_unit_tb.sv
// self-checking bench of the four-alarm evaluator
// assumes a one-wait read and zero-wait write slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module pae_alarm_unit_tb;
  localparam SC = 8;
  localparam logic [31:0] ROWS [10] = '{32'h08005a01, 32'h09005a00, 32'h0e009600,
    32'h0e009611, 32'h0f009601, 32'h10003201, 32'h11004601, 32'h11004620,
    32'h12003201, 32'h13003200};
  logic hclk, hresetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, q;
  logic [2:0] hsize;
  wire hready, hresp, key, evt;
  wire [31:0] hrdata;
  wire [3:0] alarm_out;
  wire signed [15:0] pv, sp, tsp, mv, mvc, rsp;
  int n_mismatch = 0;
  int checks_done = 0;
  pae_plant i_pae_plant (.hclk(hclk), .pv(pv), .sp(sp), .tsp(tsp), .mv(mv), .mvc(mvc),
    .rsp(rsp), .key(key), .evt(evt));
  pae_alarm_unit #(.SAMPLE_CYC(SC)) i_pae_alarm_unit (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .process_value(pv), .set_point(sp), .target_set_point(tsp), .manipulated_value(mv),
    .manipulated_value_cool(mvc), .remote_set_point(rsp), .function_key(key),
    .event_latch_release(evt), .alarm_out(alarm_out));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // one single transfer, read data left in q
  task automatic xfer(input [31:0] a, input w, input [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task wt(input int n);
    repeat (n * SC + 3) @(posedge hclk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    test_done;
  end
  initial begin
    logic [31:0] r;
    hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; hresetn = 0;
    hsize = 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int n = 1; n <= 4; n++) begin
      xfer(32'(n * 16), 0, 0); `CHK("type", 32'h2, q)
      xfer(32'(n * 16 + 4), 0, 0); `CHK("value", 32'ha, q)
      xfer(32'(n * 16 + 12), 0, 0); `CHK("hys", 32'h2, q)
    end
    xfer(32'h4, 0, 0); `CHK("rate", 32'h14, q)
    xfer(32'h0, 0, 0); `CHK("ctrl", 32'h0, q)
    xfer(32'h4, 1, 0); xfer(32'h4, 0, 0); `CHK("rate min", 32'h1, q)
    xfer(32'h4, 1, 1000); xfer(32'h4, 0, 0); `CHK("rate max", 32'h3e7, q)
    xfer(32'hfc, 1, 32'h5a); xfer(32'hfc, 0, 0); `CHK("unmapped", 32'h0, q)
    xfer(32'h40, 1, 16); xfer(32'h4c, 0, 0); `CHK("mv hys", 32'h32, q)
    xfer(32'h40, 1, 2); xfer(32'h4c, 0, 0); `CHK("hys back", 32'h2, q)
    $display("test registers done");
    xfer(32'h2c, 1, 0);
    i_pae_plant.set_pv(111); wt(1); `CHK("dev on", 4'hf, alarm_out)
    i_pae_plant.set_pv(109); wt(1); `CHK("dev hys", 4'hd, alarm_out)
    i_pae_plant.set_pv(108); wt(1); `CHK("dev off", 4'h0, alarm_out)
    $display("test hysteresis done");
    xfer(32'h30, 1, 1); xfer(32'h38, 1, 32'h00140014);
    xfer(32'h40, 1, 5); xfer(32'h48, 1, 32'h00010001);
    i_pae_plant.set_pv(79); wt(1); `CHK("limits", 4'h4, alarm_out)
    $display("test limits done");
    xfer(32'h0, 1, 32'h200); xfer(32'h0, 1, 0); xfer(32'h20, 1, 7); wt(1);
    `CHK("standby held", 4'h4, alarm_out)
    i_pae_plant.set_pv(100); wt(1); `CHK("standby out", 4'h0, alarm_out)
    i_pae_plant.set_pv(79); wt(1); `CHK("standby in", 4'h6, alarm_out)
    xfer(32'h8, 0, 0); `CHK("stat", 5'h06, {q[5], q[3:0]})
    $display("test standby done");
    for (int k = 0; k < 3; k++) begin
      xfer(32'h0, 1, 32'h40); i_pae_plant.set_pv(79); wt(1);
      i_pae_plant.set_pv(100); wt(1); `CHK("latched", 4'h4, alarm_out)
      if (k < 2) i_pae_plant.press(k[0]); else xfer(32'h0, 1, 32'h540);
      wt(1); `CHK("cleared", 4'h0, alarm_out)
    end
    $display("test latch done");
    xfer(32'h0, 1, 32'h10);
    xfer(32'h20, 1, 0); xfer(32'h30, 1, 0); xfer(32'h40, 1, 0);
    xfer(32'h4, 1, 2); xfer(32'h14, 1, 5); xfer(32'h10, 1, 13); wt(6);
    i_pae_plant.set_pv(104); wt(6); `CHK("rate small", 4'h0, alarm_out)
    i_pae_plant.set_pv(110); wt(6); `CHK("rate rise", 4'h1, alarm_out)
    i_pae_plant.press(0); wt(1); `CHK("rate clear", 4'h0, alarm_out)
    xfer(32'h14, 1, 32'hfffb); i_pae_plant.set_pv(103); wt(6);
    `CHK("rate fall", 4'h1, alarm_out)
    i_pae_plant.press(1); wt(1); `CHK("rate clear", 4'h0, alarm_out)
    $display("test rate done");
    for (int i = 0; i < 10; i++) begin
      r = ROWS[i];
      xfer(32'h10, 1, 0); xfer(32'h0, 1, {28'h0, r[7:4]});
      xfer(32'h14, 1, {16'h0, r[23:8]}); xfer(32'h10, 1, {27'h0, r[28:24]}); wt(1);
      `CHK("kind", r[0], alarm_out[0])
    end
    $display("test kinds done");
    i_pae_plant.set_in(5, 40); wt(1); `CHK("rsp low", 1'b1, alarm_out[0])
    i_pae_plant.set_in(3, 40); xfer(32'h0, 1, 2); xfer(32'h10, 1, 16); wt(1);
    `CHK("mv heat off", 1'b0, alarm_out[0])
    i_pae_plant.set_in(3, 70); wt(1); `CHK("mv heat on", 1'b1, alarm_out[0])
    xfer(32'h10, 1, 17); i_pae_plant.set_in(4, 20); wt(1);
    `CHK("mv cool on", 1'b1, alarm_out[0])
    xfer(32'h10, 1, 14); xfer(32'h14, 1, 150); xfer(32'h0, 1, 0);
    i_pae_plant.set_in(1, 160); wt(1); `CHK("ramp sp", 1'b1, alarm_out[0])
    xfer(32'h0, 1, 1); i_pae_plant.set_in(2, 120); wt(1);
    `CHK("target sp", 1'b0, alarm_out[0])
    $display("test inputs done");
    test_done;
  end
endmodule
